//--- hdl/mabc_map.svh
// Constants for the bit, add and call execution block.
// Assumes inclusion by hdl files only; definitions only.
`ifndef MABC_MAP_SVH
`define MABC_MAP_SVH
`define MABC_ACC_RST 8'h00
`define MABC_FLAG_RST 1'b0
`define MABC_PC_RST 11'h000
`define MABC_SP_RST 3'h0
`define MABC_STACK_DEPTH 5
`define MABC_RF_DEPTH 64
`define MABC_RF_RST 8'h00
`define MABC_CARRY_BIT 8
`define MABC_HALF_BIT 4
`define MABC_PCHB_SEL 2
`endif

//--- hdl/mabc_pkg.sv
// Types shared by the execution block files.
// Assumes a single 25 MHz core clock.
package mabc_pkg;
    // Decoded operation
    typedef enum logic [4:0] {
        MABC_OP_NONE = 5'h00,
        MABC_OP_ADD = 5'h01,
        MABC_OP_AND = 5'h02,
        MABC_OP_BIT = 5'h04,
        MABC_OP_SKIP = 5'h08,
        MABC_OP_CALL = 5'h10
    } mabc_kind_t;

    // One instruction as issued by the fetch stage
    typedef struct packed {
        logic add_reg_with_carry_op;
        logic add_reg_op;
        logic add_immediate_op;
        logic and_reg_op;
        logic and_immediate_op;
        logic bit_clear_op;
        logic bit_set_op;
        logic skip_if_bit_clear_op;
        logic skip_if_bit_set_op;
        logic call_op;
        logic dest_sel;
        logic [5:0] reg_addr;
        logic [2:0] bit_pos;
        logic [9:0] imm;
    } mabc_instr_t;

    // Status flags
    typedef struct packed {
        logic half_carry_flag;
        logic carry;
        logic zero;
    } mabc_flags_t;

    // Execution state
    typedef enum logic [1:0] {
        MABC_ST_RUN = 2'h1,
        MABC_ST_FLUSH = 2'h2
    } mabc_state_t;
endpackage : mabc_pkg

//--- hdl/mabc_alu.sv
// Eight-bit adder and AND unit with flag generation.
// Assumes operands come from the same clock domain; purely combinational.
`include "mabc_map.svh"
module mabc_alu (
    // Operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire logic do_and,
    // Result
    output logic [7:0] result,
    output mabc_pkg::mabc_flags_t flags
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    // Sum with carry out of bit 7 and bit 3
    always_comb begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        result = do_and ? (a & b) : sum[7:0];
        flags.carry = sum[`MABC_CARRY_BIT];
        flags.half_carry_flag = low_sum[`MABC_HALF_BIT];
        flags.zero = (result == 8'h00);
    end
endmodule : mabc_alu

//--- hdl/mabc_exec.sv
// Execution of add, AND, bit and call instructions of the 8-bit core.
// Assumes the fetch stage presents one instruction per cycle with issue_valid,
// and that instr_pc is the address of the instruction being issued.
`include "mabc_map.svh"
// Summary of operation
// - Add register, accumulator and carry
// - Destination bit picks accumulator or register
// - Add register and accumulator, no carry-in
// - Add immediate into accumulator
// - AND register, only zero flag changes
// - AND immediate, only zero flag changes
// - Clear chosen register bit, flags kept
// - Set chosen register bit, flags kept
// - Skip next when bit is clear
// - Skip next when bit is set
// - Skip discards prefetch, runs a no-op
// - Call pushes PC+1, loads target, two cycles
// - Separate half carry flag kept
module mabc_exec #(
    parameter int STACK_DEPTH = `MABC_STACK_DEPTH,
    parameter int RF_DEPTH = `MABC_RF_DEPTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Instruction issue
    input wire logic issue_valid,
    input wire mabc_pkg::mabc_instr_t instr,
    input wire logic [10:0] instr_pc,
    input wire logic [7:0] pc_high_buffer,
    // Control outputs to fetch
    output logic discard_prefetch,
    output logic pc_load,
    output logic [10:0] pc_target,
    // Architectural state
    output logic [7:0] accumulator,
    output mabc_pkg::mabc_flags_t flags,
    output logic [2:0] stack_level,
    output logic [10:0] stack_top,
    output logic busy
);
    // Storage, state registers and their next values
    logic [7:0] rf_r [RF_DEPTH];
    logic [10:0] stack_r [STACK_DEPTH];
    logic [7:0] acc_r, acc_nxt;
    mabc_pkg::mabc_flags_t flags_r, flags_nxt;
    logic [2:0] sp_r, sp_nxt;
    mabc_pkg::mabc_state_t state_r, state_nxt;
    logic pc_load_r, pc_load_nxt;
    logic [10:0] pc_target_r, pc_target_nxt;
    logic rf_we;
    logic [7:0] rf_wdata;
    logic push;
    logic [7:0] reg_val;
    logic [7:0] alu_b;
    logic alu_cin;
    logic alu_and;
    logic [7:0] alu_res;
    mabc_pkg::mabc_flags_t alu_flags;
    logic accept;
    logic tested_bit;

    // Register read port and the bit under test
    assign reg_val = rf_r[instr.reg_addr];
    assign accept = issue_valid && (state_r == mabc_pkg::MABC_ST_RUN);
    assign tested_bit = reg_val[instr.bit_pos];

    // Operand select for the shared ALU
    always_comb begin
        alu_and = instr.and_reg_op || instr.and_immediate_op;
        alu_b = (instr.add_immediate_op || instr.and_immediate_op) ? instr.imm[7:0] : reg_val;
        alu_cin = instr.add_reg_with_carry_op & flags_r.carry;
    end

    // Shared adder and AND unit
    mabc_alu u_alu (
        .a(acc_r),
        .b(alu_b),
        .cin(alu_cin),
        .do_and(alu_and),
        .result(alu_res),
        .flags(alu_flags)
    );

    // Next state of accumulator, flags, register file write and control
    always_comb begin
        acc_nxt = acc_r;
        flags_nxt = flags_r;
        sp_nxt = sp_r;
        state_nxt = mabc_pkg::MABC_ST_RUN;
        pc_load_nxt = 1'b0;
        pc_target_nxt = pc_target_r;
        rf_we = 1'b0;
        rf_wdata = reg_val;
        push = 1'b0;
        if (accept) begin
            if (instr.add_reg_with_carry_op || instr.add_reg_op) begin
                // all three flags from the sum
                flags_nxt = alu_flags;
                if (instr.dest_sel) begin
                    rf_we = 1'b1;
                    rf_wdata = alu_res;
                end else begin
                    acc_nxt = alu_res;
                end
            end else if (instr.add_immediate_op) begin
                flags_nxt = alu_flags;
                acc_nxt = alu_res;
            end else if (instr.and_reg_op) begin
                flags_nxt.zero = alu_flags.zero;
                if (instr.dest_sel) begin
                    rf_we = 1'b1;
                    rf_wdata = alu_res;
                end else begin
                    acc_nxt = alu_res;
                end
            end else if (instr.and_immediate_op) begin
                flags_nxt.zero = alu_flags.zero;
                acc_nxt = alu_res;
            end else if (instr.bit_clear_op) begin
                rf_we = 1'b1;
                rf_wdata[instr.bit_pos] = 1'b0;
            end else if (instr.bit_set_op) begin
                rf_we = 1'b1;
                rf_wdata[instr.bit_pos] = 1'b1;
            end else if (instr.skip_if_bit_clear_op) begin
                if (!tested_bit) begin
                    state_nxt = mabc_pkg::MABC_ST_FLUSH;
                end
            end else if (instr.skip_if_bit_set_op) begin
                if (tested_bit) begin
                    state_nxt = mabc_pkg::MABC_ST_FLUSH;
                end
            end else if (instr.call_op) begin
                push = 1'b1;
                // Full stack: level holds, oldest entry is lost
                if (sp_r < 3'(STACK_DEPTH)) begin
                    sp_nxt = sp_r + 3'h1;
                end
                pc_load_nxt = 1'b1;
                pc_target_nxt = {pc_high_buffer[`MABC_PCHB_SEL], instr.imm};
                state_nxt = mabc_pkg::MABC_ST_FLUSH;
            end
        end
    end

    // Architectural registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            acc_r <= `MABC_ACC_RST;
            flags_r <= {3{`MABC_FLAG_RST}};
            sp_r <= `MABC_SP_RST;
            state_r <= mabc_pkg::MABC_ST_RUN;
            pc_load_r <= 1'b0;
            pc_target_r <= `MABC_PC_RST;
        end else begin
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            sp_r <= sp_nxt;
            state_r <= state_nxt;
            pc_load_r <= pc_load_nxt;
            pc_target_r <= pc_target_nxt;
        end
    end

    // Register file, one entry per address
    for (genvar i = 0; i < RF_DEPTH; i++) begin : g_rf
        always_ff @(posedge clock) begin
            if (!rstn) begin
                rf_r[i] <= `MABC_RF_RST;
            end else if (rf_we && (instr.reg_addr == 6'(i))) begin
                rf_r[i] <= rf_wdata;
            end
        end
    end

    // Hardware stack shifts down on push; deepest entry falls off
    for (genvar j = 0; j < STACK_DEPTH; j++) begin : g_stack
        if (j == 0) begin : g_head
            // return address is PC plus one
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    stack_r[j] <= `MABC_PC_RST;
                end else if (push) begin
                    stack_r[j] <= instr_pc + 11'h001;
                end
            end
        end else begin : g_tail
            // Older entries move one place down
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    stack_r[j] <= `MABC_PC_RST;
                end else if (push) begin
                    stack_r[j] <= stack_r[j - 1];
                end
            end
        end
    end

    // second cycle replaces prefetched word with a no-op
    assign discard_prefetch = (state_r == mabc_pkg::MABC_ST_FLUSH);
    assign busy = discard_prefetch;
    assign pc_load = pc_load_r;
    assign pc_target = pc_target_r;
    assign accumulator = acc_r;
    assign flags = flags_r;
    assign stack_level = sp_r;
    assign stack_top = stack_r[0];
endmodule : mabc_exec

//--- dv/mabc_exec_asserts.sv
// Port checker for the execution block.
// Assumes binding onto mabc_exec; one clock, synchronous active-low reset.
module mabc_exec_asserts #(
    parameter int STACK_DEPTH = 5
) (
    // Clock, reset and issue
    input wire logic clock,
    input wire logic rstn,
    input wire logic issue_valid,
    input wire mabc_pkg::mabc_instr_t instr,
    input wire logic [10:0] instr_pc,
    input wire logic [7:0] pc_high_buffer,
    // Results
    input wire logic discard_prefetch,
    input wire logic pc_load,
    input wire logic [10:0] pc_target,
    input wire logic [7:0] accumulator,
    input wire mabc_pkg::mabc_flags_t flags,
    input wire logic [2:0] stack_level,
    input wire logic [10:0] stack_top,
    input wire logic busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // Expected values formed at the issue edge
    wire logic tk = issue_valid && !busy;
    wire logic br = tk && (instr.call_op || instr.skip_if_bit_clear_op
        || instr.skip_if_bit_set_op);
    wire logic [4:0] hs = accumulator[3:0] + instr.imm[3:0];
    wire logic [8:0] sm = accumulator + instr.imm[7:0];
    wire logic [9:0] addi = {hs[4], sm};
    wire logic [7:0] andi = accumulator & instr.imm[7:0];
    wire logic [10:0] tgt = {pc_high_buffer[2], instr.imm};
    wire logic [10:0] ret = instr_pc + 11'h001;
    sequence s_call;
        tk && instr.call_op;
    endsequence
    sequence s_dead;
        busy ##1 !busy;
    endsequence
    a_call_target: assert property (s_call |=> pc_load && pc_target == $past(tgt))
        else $error("call target wrong");
    a_call_push: assert property (s_call |=> stack_top == $past(ret))
        else $error("return address wrong");
    a_call_two: assert property (s_call |=> s_dead)
        else $error("call length wrong");
    a_stack_count: assert property (tk && instr.call_op && stack_level < STACK_DEPTH
        |=> stack_level == $past(stack_level) + 3'h1) else $error("stack level wrong");
    a_discard_cause: assert property (discard_prefetch |-> $past(br))
        else $error("discard without cause");
    a_busy_same: assert property (busy |-> discard_prefetch ##1 !busy)
        else $error("busy not a single discard cycle");
    a_addi_sum: assert property (tk && instr.add_immediate_op |=>
        {flags.half_carry_flag, flags.carry, accumulator} == $past(addi)
        && flags.zero == (accumulator == 8'h00)) else $error("add immediate wrong");
    a_andi_zero: assert property (tk && instr.and_immediate_op |=>
        accumulator == $past(andi) && $stable(flags.carry) && $stable(flags.half_carry_flag)
        && flags.zero == (accumulator == 8'h00)) else $error("and immediate wrong");
    a_bit_quiet: assert property (tk && (instr.bit_clear_op || instr.bit_set_op)
        |=> $stable(flags) && $stable(accumulator) && !busy) else $error("bit op side effect");
    a_load_cause: assert property (pc_load |-> $past(tk && instr.call_op))
        else $error("pc load without call");
    a_and_reg_flags: assert property (tk && instr.and_reg_op |=>
        $stable(flags.carry) && $stable(flags.half_carry_flag))
        else $error("and register flags wrong");
endmodule : mabc_exec_asserts

bind mabc_exec mabc_exec_asserts #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.clock(clock),
    .rstn(rstn), .issue_valid(issue_valid), .instr(instr), .instr_pc(instr_pc),
    .pc_high_buffer(pc_high_buffer), .discard_prefetch(discard_prefetch), .pc_load(pc_load),
    .pc_target(pc_target), .accumulator(accumulator), .flags(flags),
    .stack_level(stack_level), .stack_top(stack_top), .busy(busy));

//--- dv/mcu_alu_bit_call_exec_tb_top.sv
// Self-checking bench for the execution block.
// Assumes the port checker is bound in; the bench drives every input port.
module mcu_alu_bit_call_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus and observed ports
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic issue_valid = 1'b0;
    mabc_pkg::mabc_instr_t instr = '0;
    logic [10:0] instr_pc = 11'h000;
    logic [7:0] pc_high_buffer = 8'h00;
    logic discard_prefetch, pc_load, busy;
    logic [10:0] pc_target, stack_top;
    logic [7:0] accumulator;
    mabc_pkg::mabc_flags_t flags;
    logic [2:0] stack_level;
    int mismatches = 0;
    int checked = 0;
    logic [40:0] rows [17];
    mabc_exec #(.STACK_DEPTH(5), .RF_DEPTH(64)) uut (.clock(clock), .rstn(rstn),
        .issue_valid(issue_valid), .instr(instr), .instr_pc(instr_pc),
        .pc_high_buffer(pc_high_buffer), .discard_prefetch(discard_prefetch),
        .pc_load(pc_load), .pc_target(pc_target), .accumulator(accumulator),
        .flags(flags), .stack_level(stack_level), .stack_top(stack_top), .busy(busy));
    // 25 MHz clock
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic chk(logic [10:0] seen, logic [10:0] exp, string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask : chk
    // One issue, then sample after the taking edge
    task automatic run(logic [29:0] i);
        @(posedge clock);
        issue_valid <= 1'b1;
        instr <= i;
        @(posedge clock);
        issue_valid <= 1'b0;
        @(negedge clock);
    endtask : run
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // Watchdog against a hang
    initial begin
        repeat (1000) @(posedge clock);
        mismatches++;
        tally_and_finish();
    end
    // Rows: op, dest/reg/bit, imm, accumulator, flags {half, carry, zero}
    initial begin
        rows[0] = {10'h080, 10'h000, 10'h08f, 8'h8f, 3'h0};
        rows[1] = {10'h080, 10'h000, 10'h071, 8'h00, 3'h7};
        rows[2] = {10'h200, 10'h028, 10'h000, 8'h01, 3'h0};
        rows[3] = {10'h008, 10'h02f, 10'h000, 8'h01, 3'h0};
        rows[4] = {10'h080, 10'h000, 10'h08f, 8'h90, 3'h4};
        rows[5] = {10'h100, 10'h028, 10'h000, 8'h10, 3'h2};
        rows[6] = {10'h100, 10'h228, 10'h000, 8'h10, 3'h0};
        rows[7] = {10'h200, 10'h028, 10'h000, 8'ha0, 3'h0};
        rows[8] = {10'h080, 10'h000, 10'h070, 8'h10, 3'h2};
        rows[9] = {10'h010, 10'h02c, 10'h000, 8'h10, 3'h2};
        rows[10] = {10'h040, 10'h028, 10'h000, 8'h00, 3'h3};
        rows[11] = {10'h080, 10'h000, 10'h0fc, 8'hfc, 3'h0};
        rows[12] = {10'h080, 10'h000, 10'h008, 8'h04, 3'h6};
        rows[13] = {10'h020, 10'h000, 10'h03c, 8'h04, 3'h6};
        // Write-back into register 6 by carry add and AND, then read it
        rows[14] = {10'h200, 10'h230, 10'h000, 8'h04, 3'h0};
        rows[15] = {10'h040, 10'h230, 10'h000, 8'h04, 3'h0};
        rows[16] = {10'h100, 10'h030, 10'h000, 8'h08, 3'h0};
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        for (int k = 0; k < 17; k++) begin
            run(rows[k][40:11]);
            chk(accumulator, rows[k][10:3], "accumulator");
            chk(flags, rows[k][2:0], "flags");
        end
        $display("table test done");
        // Register 5 now holds 80h: test bit 7 and bit 0 both ways
        for (int k = 0; k < 4; k++) begin
            run({k < 2 ? 10'h002 : 10'h004, k[0] ? 10'h028 : 10'h02f, 10'h000});
            chk(busy, 11'(k == 0 || k == 3), "skip decision");
        end
        $display("skip test done");
        // Word offered during the skip is dropped
        @(posedge clock);
        issue_valid <= 1'b1;
        instr <= {10'h002, 10'h02f, 10'h000};
        @(posedge clock);
        instr <= {10'h080, 10'h000, 10'h0ff};
        @(negedge clock);
        chk(discard_prefetch, 11'h001, "no discard");
        @(posedge clock);
        issue_valid <= 1'b0;
        @(negedge clock);
        chk(accumulator, 11'h008, "discarded word ran");
        $display("discard test done");
        // Six calls: target, return address, level saturation
        @(posedge clock);
        instr_pc <= 11'h123;
        pc_high_buffer <= 8'h04;
        for (int k = 0; k < 6; k++) begin
            run({10'h001, 10'h000, 10'h2a0 + 10'(k)});
            chk(pc_load, 11'h001, "no pc load");
            chk(pc_target, 11'h6a0 + 11'(k), "call target");
            chk(stack_top, 11'h124, "return address");
            chk(stack_level, 11'(k < 5 ? k + 1 : 5), "stack level");
        end
        $display("call test done");
        // Reset in mid-run clears the state
        @(posedge clock);
        rstn <= 1'b0;
        @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        chk(accumulator, 11'h000, "reset accumulator");
        chk(flags, 11'h000, "reset flags");
        chk(stack_level, 11'h000, "reset stack");
        chk(stack_top, 11'h000, "reset stack top");
        chk(busy, 11'h000, "reset busy");
        chk(pc_load, 11'h000, "reset pc load");
        $display("reset test done");
        tally_and_finish();
    end
endmodule : mcu_alu_bit_call_exec_tb_top
